// ==== hdl/dsp_ctl_top.sv ====
// The address map and register access over APB were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module dsp_ctl_top (
   input  wire logic                          pclk,
   input  wire logic                          presetn,
   input  wire logic                          psel,
   input  wire logic                          penable,
   input  wire logic                          pwrite,
   input  wire logic [dsp_ctl_pkg::AW-1:0]    paddr,
   input  wire logic [31:0]                   pwdata,
   output logic      [31:0]                   prdata,
   output logic                               pready,
   output logic                               pslverr,
   input  wire logic [dsp_ctl_pkg::NCLK-1:0]  blk_clock,
   input  wire logic [dsp_ctl_pkg::OPW27-1:0] casc_in,
   input  wire logic [dsp_ctl_pkg::ACCW-1:0]  chain_in,
   output logic      [dsp_ctl_pkg::OPW27-1:0] casc_out,
   output logic      [dsp_ctl_pkg::ACCW-1:0]  chain_out
);
   localparam int OPW   = dsp_ctl_pkg::OPW;
   localparam int ACCW  = dsp_ctl_pkg::ACCW;
   localparam int FW    = dsp_ctl_pkg::FIFO_W;
   localparam int NCLK  = dsp_ctl_pkg::NCLK;

   // ****************************************************
   // Control and operand registers.
   // ****************************************************
   logic [31:0]   ctrl;
   logic [31:0]   clksel;
   logic [OPW-1:0] opx0;
   logic [OPW-1:0] opx1;
   logic [OPW-1:0] opy0;
   logic [ACCW-1:0] preload_val;
   logic [OPW-1:0] coef [dsp_ctl_pkg::COEF_N];
   logic [ACCW-1:0] acc;

   wire decimation_ctl = ctrl[dsp_ctl_pkg::CTRL_DECIM];
   wire acc_preload    = ctrl[dsp_ctl_pkg::CTRL_PRELOAD];
   wire acc_enable     = ctrl[dsp_ctl_pkg::CTRL_ACC_EN];
   wire sub_sel        = ctrl[dsp_ctl_pkg::CTRL_SUB];
   wire coef_pick_a    = ctrl[dsp_ctl_pkg::CTRL_COEF_A];
   wire coef_pick_b    = ctrl[dsp_ctl_pkg::CTRL_COEF_B];
   wire coef_use       = ctrl[dsp_ctl_pkg::CTRL_COEF_USE];
   wire casc_sel       = ctrl[dsp_ctl_pkg::CTRL_CASC];
   wire [NCLK-1:0] blk_clk_en = ctrl[dsp_ctl_pkg::CTRL_EN0 +: NCLK];
   wire [1:0] async_clear = ctrl[dsp_ctl_pkg::CTRL_CLR0 +: dsp_ctl_pkg::NCLR];
   wire [1:0] mode        = ctrl[dsp_ctl_pkg::CTRL_MODE +: 2];
   wire [1:0] in_clk      = clksel[dsp_ctl_pkg::SEL_IN_CLK +: 2];
   wire [1:0] out_clk     = clksel[dsp_ctl_pkg::SEL_OUT_CLK +: 2];
   wire mode_sum18 = (mode == dsp_ctl_pkg::MODE_SUM18);
   wire mode_sys27 = (mode == dsp_ctl_pkg::MODE_SYS27);
   wire mode_m36   = (mode == dsp_ctl_pkg::MODE_M36);

   // ****************************************************
   // Block clock pins: three-stage sampling and edge ticks.
   // ****************************************************
   logic [NCLK-1:0] clk_s1;
   logic [NCLK-1:0] clk_s2;
   logic [NCLK-1:0] clk_s3;
   logic [NCLK-1:0] clk_lvl;
   logic [NCLK-1:0] clk_tick;
   wire  [NCLK-1:0] agree = ~(clk_s2 ^ clk_s3);
   wire  [NCLK-1:0] next_lvl = (agree & clk_s2) | (~agree & clk_lvl);
   wire  [NCLK-1:0] next_tick = next_lvl & ~clk_lvl;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         clk_s1   <= '0;
         clk_s2   <= '0;
         clk_s3   <= '0;
         clk_lvl  <= '0;
         clk_tick <= '0;
      end else begin
         clk_s1   <= blk_clock;
         clk_s2   <= clk_s1;
         clk_s3   <= clk_s2;
         clk_lvl  <= next_lvl;
         clk_tick <= next_tick;
      end
   end

   // Each stage picks one clock; its enable is the one paired with that clock.
   wire sel_in_ok  = (in_clk < 2'(NCLK));
   wire sel_out_ok = (out_clk < 2'(NCLK));
   wire in_edge    = sel_in_ok & clk_tick[in_clk];
   wire out_edge   = sel_out_ok & clk_tick[out_clk];
   wire in_en      = sel_in_ok & blk_clk_en[in_clk];
   wire out_en     = sel_out_ok & blk_clk_en[out_clk];
   wire clr_in     = async_clear[clksel[dsp_ctl_pkg::SEL_IN_CLR]];
   wire clr_out    = async_clear[clksel[dsp_ctl_pkg::SEL_OUT_CLR]];

   // ****************************************************
   // APB slave decode.
   // ****************************************************
   wire acc_phase = psel & penable;
   wire wr_fire   = acc_phase & pready & pwrite;
   wire hit_ctrl  = (paddr == dsp_ctl_pkg::CTRL_OFS);
   wire hit_sel   = (paddr == dsp_ctl_pkg::CLKSEL_OFS);
   wire hit_x0    = (paddr == dsp_ctl_pkg::OPX0_OFS);
   wire hit_x1    = (paddr == dsp_ctl_pkg::OPX1_OFS);
   wire hit_y0    = (paddr == dsp_ctl_pkg::OPY0_OFS);
   wire hit_push  = (paddr == dsp_ctl_pkg::OPY1_OFS);
   wire hit_pl    = (paddr == dsp_ctl_pkg::PREL_LO_OFS);
   wire hit_ph    = (paddr == dsp_ctl_pkg::PREL_HI_OFS);
   wire hit_rl    = (paddr == dsp_ctl_pkg::RES_LO_OFS);
   wire hit_rh    = (paddr == dsp_ctl_pkg::RES_HI_OFS);
   wire hit_st    = (paddr == dsp_ctl_pkg::STATUS_OFS);
   wire hit_coef  = (paddr[11:5] == dsp_ctl_pkg::COEF_OFS[11:5]);
   wire [2:0] coef_idx = paddr[4:2];
   wire addr_hit  = hit_ctrl | hit_sel | hit_x0 | hit_x1 | hit_y0 | hit_push |
                    hit_pl | hit_ph | hit_rl | hit_rh | hit_st | hit_coef;

   op_if #(.W(FW)) in_q ();
   op_if #(.W(FW)) out_q ();
   logic [2:0] fifo_level;

   // A push to a full queue waits in the access phase until a slot frees.
   wire push_stall = pwrite & hit_push & ~in_q.ready;
   wire next_pready = acc_phase & ~pready & ~push_stall;
   wire [31:0] status_word = {27'h0000000, ~in_q.ready, out_q.valid,
                              fifo_level};
   wire [31:0] rd_mux =
      hit_ctrl ? ctrl :
      hit_sel  ? clksel :
      hit_x0   ? {14'h0000, opx0} :
      hit_x1   ? {14'h0000, opx1} :
      hit_y0   ? {14'h0000, opy0} :
      hit_pl   ? preload_val[31:0] :
      hit_ph   ? preload_val[63:32] :
      hit_rl   ? acc[31:0] :
      hit_rh   ? acc[63:32] :
      hit_st   ? status_word :
      hit_coef ? {14'h0000, coef[coef_idx]} : 32'h0000_0000;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else begin
         pready  <= next_pready;
         pslverr <= next_pready & ~addr_hit;
         prdata  <= (next_pready & ~pwrite) ? rd_mux : 32'h0000_0000;
      end
   end

   // Every control may be rewritten at any time while running.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl        <= dsp_ctl_pkg::CTRL_RST;
         clksel      <= dsp_ctl_pkg::CLKSEL_RST;
         opx0        <= '0;
         opx1        <= '0;
         opy0        <= '0;
         preload_val <= '0;
      end else if (wr_fire) begin
         if (hit_ctrl) ctrl <= pwdata;
         if (hit_sel)  clksel <= pwdata;
         if (hit_x0)   opx0 <= pwdata[OPW-1:0];
         if (hit_x1)   opx1 <= pwdata[OPW-1:0];
         if (hit_y0)   opy0 <= pwdata[OPW-1:0];
         if (hit_pl)   preload_val[31:0] <= pwdata;
         if (hit_ph)   preload_val[63:32] <= pwdata;
      end
   end

   always_ff @(posedge pclk) begin
      if (wr_fire && hit_coef) begin
         coef[coef_idx] <= pwdata[OPW-1:0];
      end
   end

   // ****************************************************
   // Operand queue.
   // ****************************************************
   assign in_q.valid = wr_fire & hit_push;
   assign in_q.data  = {opx0, opx1, opy0, pwdata[OPW-1:0]};

   op_fifo #(.W(FW), .DEPTH(dsp_ctl_pkg::FIFO_DEPTH)) queue (
      .clk   (pclk),
      .rst_n (presetn),
      .wr    (in_q),
      .rd    (out_q),
      .level (fifo_level)
   );

   // ****************************************************
   // Input stage and cascade.
   // ****************************************************
   logic [FW-1:0] stage_q;
   logic          stage_vld;
   wire  in_fire  = in_edge & in_en & ~clr_in;
   wire  out_fire = out_edge & out_en & ~clr_out & stage_vld;
   wire  pop      = in_fire & out_q.valid & (~stage_vld | out_fire);
   assign out_q.ready = pop;

   // Cascade replaces the x operand with the neighbour's 27-bit word.
   localparam int OPW27_HI = dsp_ctl_pkg::OPW27 - 1;
   wire [FW-1:0] casc_word = {casc_in[OPW-1:0],
                              {(OPW-9){1'b0}}, casc_in[OPW27_HI:OPW],
                              out_q.data[2*OPW-1:0]};
   wire [FW-1:0] stage_d = casc_sel ? casc_word : out_q.data;

   reg_stage #(.W(FW)) in_stage (
      .clk   (pclk),
      .rst_n (presetn),
      .load  (pop),
      .clr   (clr_in),
      .d     (stage_d),
      .q     (stage_q)
   );

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stage_vld <= 1'b0;
      end else if (clr_in) begin
         stage_vld <= 1'b0;
      end else if (pop || out_fire) begin
         stage_vld <= pop;
      end
   end

   wire [OPW-1:0] x0 = stage_q[4*OPW-1:3*OPW];
   wire [OPW-1:0] x1 = stage_q[3*OPW-1:2*OPW];
   wire [OPW-1:0] y0r = stage_q[2*OPW-1:OPW];
   wire [OPW-1:0] y1r = stage_q[OPW-1:0];
   wire [26:0] x27 = {x1[8:0], x0};
   // In MODE_SUM18 the upper nine cascade bits are forced to zero.
   wire [26:0] casc_d = mode_sum18 ? {9'h000, x0} : x27;

   reg_stage #(.W(dsp_ctl_pkg::OPW27)) casc_stage (
      .clk   (pclk),
      .rst_n (presetn),
      .load  (out_fire),
      .clr   (clr_out),
      .d     (casc_d),
      .q     (casc_out)
   );

   // ****************************************************
   // Coefficient multiplexer and multipliers.
   // ****************************************************
   wire [2:0] ca_idx = {1'b0, coef_pick_a, x0[OPW-1]};
   wire [2:0] cb_idx = {1'b1, coef_pick_b, x1[OPW-1]};
   wire [OPW-1:0] y0 = coef_use ? coef[ca_idx] : y0r;
   wire [OPW-1:0] y1 = coef_use ? coef[cb_idx] : y1r;
   wire [26:0] y27 = coef_use ? {{9{y0[OPW-1]}}, y0} : {y1r[8:0], y0r};

   wire signed [35:0]  p0  = $signed(x0) * $signed(y0);
   wire signed [35:0]  p1  = $signed(x1) * $signed(y1);
   wire signed [53:0]  p27 = $signed(x27) * $signed(y27);
   wire signed [71:0]  p72 = $signed({x1, x0}) * $signed({y1, y0});
   wire signed [ACCW-1:0] e0 = ACCW'(p0);
   wire signed [ACCW-1:0] e1 = ACCW'(p1);
   wire signed [ACCW-1:0] e27 = ACCW'(p27);

   wire [ACCW-1:0] sum18 = sub_sel ? e0 - e1 : e0 + e1;
   wire [ACCW-1:0] m36 = sub_sel ? e0 - e1 : p72[ACCW-1:0];
   wire [ACCW-1:0] raw_term = mode_sys27 ? e27 : mode_m36 ? m36 : sum18;
   wire [ACCW-1:0] term = decimation_ctl ? -raw_term : raw_term;

   // ****************************************************
   // Accumulator and systolic chain.
   // ****************************************************
   // One systolic stage: in MODE_SYS27 the chain input joins this block's product.
   wire [ACCW-1:0] chain_add = mode_sys27 ? chain_in : '0;
   wire [ACCW-1:0] base = acc_enable ? acc : '0;
   wire [ACCW-1:0] next_acc = acc_preload ? preload_val :
                              base + term + chain_add;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         acc <= '0;
      end else if (clr_out) begin
         acc <= '0;
      end else if (out_fire) begin
         acc <= next_acc;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         chain_out <= '0;
      end else if (clr_out) begin
         chain_out <= '0;
      end else if (out_fire) begin
         chain_out <= next_acc;
      end
   end

   // ****************************************************
   // Checks.
   // ****************************************************
   sequence pin_rise_held(int i);
      !blk_clock[i] ##1 blk_clock[i] [*4];
   endsequence

   a_tick_from_pin: assert property (@(posedge pclk) disable iff (!presetn)
      pin_rise_held(0) |-> ##1 clk_tick[0])
      else $error("block clock rise produced no tick");

   a_stage_hold: assert property (@(posedge pclk) disable iff (!presetn)
      (!pop && !clr_in) |=> $stable(stage_q))
      else $error("input stage changed without load");

   a_enable_gate: assert property (@(posedge pclk) disable iff (!presetn)
      (!in_en || !in_edge) |-> !pop)
      else $error("stage loaded with its enable low");

   a_clear_wins: assert property (@(posedge pclk) disable iff (!presetn)
      clr_out |=> (acc == '0) && (chain_out == '0))
      else $error("clear did not zero the accumulator");

   a_preload_value: assert property (@(posedge pclk) disable iff (!presetn)
      (out_fire && acc_preload) |=> acc == $past(preload_val))
      else $error("preload value not loaded");

   a_accum_sum: assert property (@(posedge pclk) disable iff (!presetn)
      (out_fire && !acc_preload && acc_enable && !mode_sys27)
      |=> acc == $past(acc) + $past(term))
      else $error("accumulation result wrong");

   a_sub_select: assert property (@(posedge pclk) disable iff (!presetn)
      (out_fire && !acc_preload && !acc_enable && mode_sum18 && !decimation_ctl)
      |=> acc == ($past(sub_sel) ? $past(e0) - $past(e1) : $past(e0) + $past(e1)))
      else $error("add or subtract of products wrong");

   a_mode_switch: assert property (@(posedge pclk) disable iff (!presetn)
      (out_fire && !acc_preload && !acc_enable && mode_m36 && !sub_sel
       && !decimation_ctl) |=> acc == $past(p72[ACCW-1:0]))
      else $error("36 x 36 product wrong");

   a_decim_decimation_ctl: assert property (@(posedge pclk) disable iff (!presetn)
      (out_fire && !acc_preload && !acc_enable && !mode_sys27 && decimation_ctl)
      |=> acc == -$past(raw_term))
      else $error("decimation control did not decimation_ctl");

   a_systolic_stage: assert property (@(posedge pclk) disable iff (!presetn)
      (out_fire && !acc_preload && !acc_enable && mode_sys27 && !decimation_ctl)
      |=> chain_out == $past(chain_in) + $past(e27))
      else $error("systolic stage sum wrong");

   a_casc_width: assert property (@(posedge pclk) disable iff (!presetn)
      (out_fire && mode_sum18 && !clr_out) |=> casc_out[26:OPW] == '0)
      else $error("18-bit cascade carries upper bits");
endmodule : dsp_ctl_top
`default_nettype wire

// ==== hdl/dsp_ctl_pkg.sv ====
`default_nettype none
package dsp_ctl_pkg;
   // ****************************************************
   // Widths and depths.
   // ****************************************************
   localparam int OPW        = 18;
   localparam int OPW27      = 27;
   localparam int ACCW       = 64;
   localparam int FIFO_W     = 4 * OPW;
   localparam int FIFO_DEPTH = 4;
   localparam int COEF_N     = 8;
   localparam int AW         = 12;
   localparam int NCLK       = 3;
   localparam int NCLR       = 2;
   // ****************************************************
   // Register byte offsets.
   // ****************************************************
   localparam logic [AW-1:0] CTRL_OFS    = 12'h000;
   localparam logic [AW-1:0] CLKSEL_OFS  = 12'h004;
   localparam logic [AW-1:0] OPX0_OFS    = 12'h008;
   localparam logic [AW-1:0] OPX1_OFS    = 12'h00c;
   localparam logic [AW-1:0] OPY0_OFS    = 12'h010;
   localparam logic [AW-1:0] OPY1_OFS    = 12'h014;
   localparam logic [AW-1:0] PREL_LO_OFS = 12'h018;
   localparam logic [AW-1:0] PREL_HI_OFS = 12'h01c;
   localparam logic [AW-1:0] RES_LO_OFS  = 12'h020;
   localparam logic [AW-1:0] RES_HI_OFS  = 12'h024;
   localparam logic [AW-1:0] STATUS_OFS  = 12'h028;
   localparam logic [AW-1:0] COEF_OFS    = 12'h040;
   // ****************************************************
   // Field positions and reset values.
   // ****************************************************
   localparam int CTRL_DECIM   = 0;
   localparam int CTRL_PRELOAD = 1;
   localparam int CTRL_ACC_EN  = 2;
   localparam int CTRL_SUB     = 3;
   localparam int CTRL_COEF_A  = 4;
   localparam int CTRL_COEF_B  = 5;
   localparam int CTRL_EN0     = 6;
   localparam int CTRL_CLR0    = 9;
   localparam int CTRL_MODE    = 11;
   localparam int CTRL_COEF_USE = 13;
   localparam int CTRL_CASC    = 14;
   localparam logic [31:0] CTRL_RST   = 32'h0000_01c0;
   localparam logic [31:0] CLKSEL_RST = 32'h0000_0000;
   localparam int SEL_IN_CLK  = 0;
   localparam int SEL_OUT_CLK = 2;
   localparam int SEL_IN_CLR  = 4;
   localparam int SEL_OUT_CLR = 5;
   localparam logic [1:0] MODE_SUM18 = 2'h0;
   localparam logic [1:0] MODE_SYS27 = 2'h1;
   localparam logic [1:0] MODE_M36   = 2'h2;
endpackage : dsp_ctl_pkg
`default_nettype wire

// ==== hdl/op_if.sv ====
`timescale 1ns/100ps
`default_nettype none
interface op_if #(parameter int W = 8);
   logic         valid;
   logic         ready;
   logic [W-1:0] data;
   modport tx (output valid, output data, input ready);
   modport rx (input valid, input data, output ready);
endinterface : op_if
`default_nettype wire

// ==== hdl/op_fifo.sv ====
`timescale 1ns/100ps
`default_nettype none
module op_fifo #(
   parameter int W     = 8,
   parameter int DEPTH = 4
) (
   input  wire logic           clk,
   input  wire logic           rst_n,
   op_if.rx                    wr,
   op_if.tx                    rd,
   output logic [$clog2(DEPTH):0] level
);
   localparam int PW = $clog2(DEPTH);
   logic [W-1:0]  mem [DEPTH];
   logic [PW-1:0] wp;
   logic [PW-1:0] rp;
   wire           do_push = wr.valid & wr.ready;
   wire           do_pop  = rd.valid & rd.ready;

   assign wr.ready = (level != (PW+1)'(DEPTH));
   assign rd.valid = (level != '0);
   assign rd.data  = mem[rp];

   always_ff @(posedge clk) begin
      if (do_push) begin
         mem[wp] <= wr.data;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wp    <= '0;
         rp    <= '0;
         level <= '0;
      end else begin
         wp    <= wp + PW'(do_push);
         rp    <= rp + PW'(do_pop);
         level <= level + (PW+1)'(do_push) - (PW+1)'(do_pop);
      end
   end
endmodule : op_fifo
`default_nettype wire

// ==== hdl/reg_stage.sv ====
`timescale 1ns/100ps
`default_nettype none
module reg_stage #(
   parameter int W = 8
) (
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic         load,
   input  wire logic         clr,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   // Clear wins over load; without load or clear the contents are held.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         q <= '0;
      end else if (clr) begin
         q <= '0;
      end else if (load) begin
         q <= d;
      end
   end
endmodule : reg_stage
`default_nettype wire

// ==== tb/fabric_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module fabric_model (
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic [2:0] go,
   output logic      [2:0] blk_clock,
   output logic            busy
);
   logic [3:0] cnt;
   logic [2:0] sel;
   // ****************************************************
   // Block clock pulses.
   // ****************************************************
   // Each request gives one pulse, four cycles high and four low, so both levels last longer than three cycles.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt       <= 4'h0;
         sel       <= 3'h0;
         blk_clock <= 3'h0;
      end else if (cnt != 4'h0) begin
         cnt       <= cnt - 4'h1;
         blk_clock <= (cnt > 4'h4) ? sel : 3'h0;
      end else if (go != 3'h0) begin
         cnt <= 4'h8;
         sel <= go;
      end
   end
   assign busy = (cnt != 4'h0);
endmodule : fabric_model
`default_nettype wire

// ==== tb/tb_dsp_ctl_top.sv ====
`timescale 1ns/100ps
`default_nettype none
module tb_dsp_ctl_top;
   logic        pclk    = 1'b0;
   logic        presetn = 1'b0;
   logic        psel    = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite  = 1'b0;
   logic [11:0] paddr   = 12'h000;
   logic [31:0] pwdata  = 32'h0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic [2:0]  blk_clock;
   logic [2:0]  go      = 3'h0;
   logic        busy;
   logic [63:0] chain_out;
   logic [63:0] chain_in = 64'h0;
   logic [26:0] casc_in  = 27'h0;
   logic [26:0] casc_out;
   logic [31:0] r;
   logic        e;
   int          n_errors    = 0;
   int          comparisons = 0;
   always #4 pclk = ~pclk;
   dsp_ctl_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .blk_clock(blk_clock), .casc_in(casc_in), .chain_in(chain_in), .casc_out(casc_out), .chain_out(chain_out));
   fabric_model u_fab (.pclk(pclk), .presetn(presetn), .go(go), .blk_clock(blk_clock), .busy(busy));
   task automatic complete_run;
      if (n_errors == 0 && comparisons > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : complete_run
   task automatic chk(input string nm, input logic [63:0] x, input logic [63:0] g);
      comparisons++;
      if (g !== x) begin
         n_errors++;
         $display("[ERR] %s expected %h seen %h", nm, x, g);
      end
   endtask : chk
   // ****************************************************
   // Bus and clock helpers.
   // ****************************************************
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 100);
      r = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      if (n >= 100) begin
         n_errors++;
         complete_run();
      end
   endtask : apb
   task automatic push(input logic [17:0] x0, x1, y0, y1);
      apb(1'b1, dsp_ctl_pkg::OPX0_OFS, {14'h0, x0});
      apb(1'b1, dsp_ctl_pkg::OPX1_OFS, {14'h0, x1});
      apb(1'b1, dsp_ctl_pkg::OPY0_OFS, {14'h0, y0});
      apb(1'b1, dsp_ctl_pkg::OPY1_OFS, {14'h0, y1});
   endtask : push
   task automatic ticks(input int k, input logic [2:0] g = 3'h1);
      int n;
      repeat (k) begin
         @(posedge pclk);
         go <= g;
         @(posedge pclk);
         go <= 3'h0;
         n = 0;
         do begin
            @(posedge pclk);
            n++;
         end while (busy !== 1'b0 && n < 50);
         if (n >= 50) begin
            n_errors++;
            complete_run();
         end
         repeat (3) @(posedge pclk);
      end
   endtask : ticks
   task automatic chk_res(input logic [63:0] x);
      apb(1'b0, dsp_ctl_pkg::RES_LO_OFS, 32'h0);
      chk("result_lo", {32'h0, x[31:0]}, {32'h0, r});
      apb(1'b0, dsp_ctl_pkg::RES_HI_OFS, 32'h0);
      chk("result_hi", {32'h0, x[63:32]}, {32'h0, r});
      chk("chain_out", x, chain_out);
   endtask : chk_res
   // ****************************************************
   // Scenarios.
   // ****************************************************
   task automatic t_reset;
      apb(1'b0, dsp_ctl_pkg::CTRL_OFS, 32'h0);
      chk("ctrl", 64'h1c0, {32'h0, r});
      apb(1'b0, dsp_ctl_pkg::CLKSEL_OFS, 32'h0);
      chk("clksel", 64'h0, {32'h0, r});
      apb(1'b0, 12'h030, 32'h0);
      chk("unmapped_err", 64'h1, {63'h0, e});
      chk("unmapped_data", 64'h0, {32'h0, r});
   endtask : t_reset
   task automatic t_addsub;
      for (int s = 0; s < 2; s++) begin
         apb(1'b1, dsp_ctl_pkg::CTRL_OFS, 32'h1c0 | (s << 3));
         push(18'h3, 18'h2, 18'h5, 18'h4);
         ticks(3);
         chk_res(s ? 64'h7 : 64'h17);
      end
   endtask : t_addsub
   task automatic t_hold;
      apb(1'b1, dsp_ctl_pkg::CTRL_OFS, 32'h180);
      push(18'h1, 18'h0, 18'h1, 18'h0);
      ticks(3);
      chk_res(64'h7);
      apb(1'b1, dsp_ctl_pkg::CTRL_OFS, 32'h1c0);
      ticks(3);
      chk_res(64'h1);
   endtask : t_hold
   task automatic t_clear_acc;
      apb(1'b1, dsp_ctl_pkg::CTRL_OFS, 32'h3c4);
      chk_res(64'h0);
      apb(1'b1, dsp_ctl_pkg::CTRL_OFS, 32'h1c4);
      repeat (4) push(18'h3, 18'h0, 18'h5, 18'h0);
      apb(1'b0, dsp_ctl_pkg::STATUS_OFS, 32'h0);
      chk("status_full", 64'h1c, {59'h0, r[4:0]});
      ticks(8);
      chk_res(64'h3c);
      apb(1'b0, dsp_ctl_pkg::STATUS_OFS, 32'h0);
      chk("status_empty", 64'h0, {59'h0, r[4:0]});
   endtask : t_clear_acc
   task automatic t_acc_ctl;
      apb(1'b1, dsp_ctl_pkg::PREL_LO_OFS, 32'h0000_0100);
      apb(1'b1, dsp_ctl_pkg::PREL_HI_OFS, 32'h0000_0001);
      apb(1'b1, dsp_ctl_pkg::CTRL_OFS, 32'h0000_01c6);
      push(18'h3, 18'h0, 18'h5, 18'h0);
      ticks(3);
      chk_res(64'h0000_0001_0000_0100);
      apb(1'b1, dsp_ctl_pkg::CTRL_OFS, 32'h0000_01c4);
      push(18'h3, 18'h0, 18'h5, 18'h0);
      ticks(3);
      chk_res(64'h0000_0001_0000_010f);
      apb(1'b1, dsp_ctl_pkg::CTRL_OFS, 32'h0000_01c1);
      push(18'h3, 18'h1, 18'h5, 18'h0);
      ticks(3);
      chk_res(64'hffff_ffff_ffff_fff1);
      chk("casc_out_18", 64'h3, {37'h0, casc_out});
   endtask : t_acc_ctl
   task automatic t_mult_modes;
      for (int s = 0; s < 2; s++) begin
         apb(1'b1, dsp_ctl_pkg::CTRL_OFS, 32'h0000_11c0 | (s << 3));
         push(18'h1, 18'h1, 18'h2, 18'h3);
         ticks(3);
         chk_res(s ? 64'hffff_ffff_ffff_ffff : 64'h0000_0030_0014_0002);
      end
      casc_in  <= 27'h004_0003;
      chain_in <= 64'h0000_0000_0000_0100;
      apb(1'b1, dsp_ctl_pkg::CTRL_OFS, 32'h0000_49c0);
      push(18'h0, 18'h0, 18'h5, 18'h1);
      ticks(3);
      chk_res(64'h0000_0010_0020_010f);
      chk("casc_out_27", 64'h40003, {37'h0, casc_out});
      apb(1'b1, dsp_ctl_pkg::COEF_OFS + 12'h008, 32'h0000_0007);
      apb(1'b1, dsp_ctl_pkg::COEF_OFS + 12'h010, 32'h0000_0002);
      apb(1'b1, dsp_ctl_pkg::CTRL_OFS, 32'h0000_21d0);
      push(18'h3, 18'h5, 18'h0, 18'h0);
      ticks(3);
      chk_res(64'h1f);
   endtask : t_mult_modes
   task automatic t_clk_sel;
      apb(1'b1, dsp_ctl_pkg::CTRL_OFS, 32'h0000_01c0);
      apb(1'b1, dsp_ctl_pkg::CLKSEL_OFS, 32'h0000_0004);
      push(18'h2, 18'h0, 18'h3, 18'h0);
      ticks(2);
      chk_res(64'h1f);
      ticks(1, 3'h2);
      chk_res(64'h6);
      apb(1'b1, dsp_ctl_pkg::CLKSEL_OFS, 32'h0000_0024);
      apb(1'b1, dsp_ctl_pkg::CTRL_OFS, 32'h0000_05c0);
      chk_res(64'h0);
      apb(1'b1, dsp_ctl_pkg::CTRL_OFS, 32'h0000_0140);
      push(18'h2, 18'h0, 18'h3, 18'h0);
      ticks(1);
      ticks(1, 3'h2);
      chk_res(64'h0);
   endtask : t_clk_sel
   task automatic t_mid_reset;
      @(posedge pclk);
      presetn <= 1'b0;
      @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      chk_res(64'h0);
   endtask : t_mid_reset
   initial begin
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_addsub();
      t_hold();
      t_clear_acc();
      t_acc_ctl();
      t_mult_modes();
      t_clk_sel();
      t_mid_reset();
      complete_run();
   end
endmodule : tb_dsp_ctl_top
`default_nettype wire
